// ### core/sadc_pkg.sv
// Constants and types for the converter sequencer and serial readout
// Behaviour
// R1: Every conversion spans exactly sixteen serial clocks, which also shift the result.
// R2: First three clocks acquire the input; the other thirteen convert and shift.
// R3: Falling edges one to four send zeros; five to sixteen send result MSB first.
// R4: Each output bit changes only on a serial clock falling edge.
// R5: Output bits belong to the conversion in progress, not a previous one.
// R6: Data line is driven while select is low, released while it is high.
// R7: Select high means power-down; select low means normal operation.
// R8: Raising select before the sixteenth falling edge aborts and releases the output.
// R9: Lowering select again after it was high starts a fresh conversion.
// R10: With select held low, conversions follow back to back, sixteen clocks each.
// R11: Acquisition resumes after each sixteenth rising edge; conversion at edge N*16+4.
// R12: Select falling with clock high: acquisition starts at the next falling edge.
// R13: Select falling with clock low counts as the first falling edge.
// R14: Select and clock falling together enter acquisition immediately.
// R15: Result is twelve-bit two's complement, 7ff top, 800 bottom, fff below zero.
// R16: Host samples the data line on serial clock rising edges.
// R17: Host may sample on falling edges only if output hold time suffices.
// R18: Host never lowers select together with a serial clock rising edge.
package sadc_pkg;

   localparam int CODE_W = 12;
   localparam int IDX_W = 4;
   // Sixteen edges per conversion; the 4-bit index wraps on its own
   localparam logic [4:0] EDGES_PER_CONV = 5'h10;
   localparam logic [IDX_W-1:0] IDX_SAMPLE_REQ = 4'h1;
   localparam logic [IDX_W-1:0] IDX_ACQ_LAST = 4'h2;
   localparam logic [IDX_W-1:0] IDX_HOLD = 4'h3;
   localparam logic [IDX_W-1:0] IDX_FIRST_DATA = 4'h4;
   localparam logic [IDX_W-1:0] IDX_LAST = 4'hf;
   localparam logic [CODE_W-1:0] CODE_POS_FULL = 12'h7ff;
   localparam logic [CODE_W-1:0] CODE_NEG_FULL = 12'h800;
   localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
   localparam int SYNC_W = 4;

   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
   } sadc_result_t;

   typedef struct packed {
      logic power_down;
      logic acquisition_phase;
      logic conversion_phase;
   } sadc_status_t;

endpackage

// ### core/sadc_serial_readout.sv
// Conversion sequencer and three-wire serial result output
`timescale 1ns/1ps
module sadc_serial_readout (
   // System clock domain
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Converter core, system clock domain
   input wire logic [sadc_pkg::CODE_W-1:0] sample_code,
   output logic sample_req,
   output logic conv_abort,
   output sadc_pkg::sadc_result_t result,
   output sadc_pkg::sadc_status_t status,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   output logic dout_o,
   output logic dout_oe
);

   // ---------------- Serial clock domain ----------------
   // Idle while select is high and until the first serial clock fall of a frame
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACQ,
      PH_CONV
   } sadc_phase_t;

   logic lowstart_reg;
   logic lowstart_next;
   logic [sadc_pkg::IDX_W-1:0] cnt_reg;
   logic [sadc_pkg::IDX_W-1:0] cnt_next;
   logic [sadc_pkg::IDX_W-1:0] idx;
   logic [sadc_pkg::CODE_W-1:0] shift_reg;
   logic [sadc_pkg::CODE_W-1:0] shift_next;
   logic dout_reg;
   logic dout_next;
   sadc_phase_t phase_reg;
   sadc_phase_t phase_next;
   logic conv_lvl;
   logic req_tgl_reg;
   logic req_tgl_next;
   logic done_tgl_reg;
   logic done_tgl_next;
   logic busy_reg;
   logic busy_next;

   // Held code from the system domain; stable from request to hold edge
   logic [sadc_pkg::CODE_W-1:0] held_reg;

   // Clock level at the select fall decides whether that fall counts as edge one
   always_comb begin
      lowstart_next = ~sclk; // R12 R13 R14
   end

   always_ff @(negedge cs_n) begin
      lowstart_reg <= lowstart_next;
   end

   always_comb begin
      idx = cnt_reg + {{(sadc_pkg::IDX_W-1){1'b0}}, lowstart_reg}; // R13
      cnt_next = cnt_reg + 4'h1; // R1 R10
      shift_next = shift_reg;
      dout_next = 1'b0; // R3
      busy_next = busy_reg;
      if (idx == sadc_pkg::IDX_SAMPLE_REQ) begin
         busy_next = 1'b1;
      end
      if (idx == sadc_pkg::IDX_HOLD) begin
         // Code was frozen by the system side well before this edge
         shift_next = held_reg; // R5 R15
      end
      if (idx >= sadc_pkg::IDX_FIRST_DATA) begin
         dout_next = shift_reg[sadc_pkg::CODE_W-1]; // R3 R4
         shift_next = {shift_reg[sadc_pkg::CODE_W-2:0], 1'b0};
      end
      if (idx == sadc_pkg::IDX_LAST) begin
         busy_next = 1'b0;
      end
   end

   // Handshake toggles move only inside a frame, never on idle clock edges
   always_comb begin
      req_tgl_next = req_tgl_reg;
      done_tgl_next = done_tgl_reg;
      if (!cs_n && idx == sadc_pkg::IDX_SAMPLE_REQ) begin
         req_tgl_next = ~req_tgl_reg; // R5
      end
      if (!cs_n && idx == sadc_pkg::IDX_LAST) begin
         done_tgl_next = ~done_tgl_reg; // R1
      end
   end

   // Phase walks acquisition, conversion and back once per sixteen edges
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         PH_IDLE: begin
            phase_next = PH_ACQ; // R12 R13 R14
         end
         PH_ACQ: begin
            if (idx >= sadc_pkg::IDX_HOLD) begin
               phase_next = PH_CONV; // R2
            end
         end
         PH_CONV: begin
            if (idx < sadc_pkg::IDX_HOLD) begin
               phase_next = PH_ACQ; // R11
            end
         end
         default: begin
            phase_next = PH_IDLE;
         end
      endcase
   end

   // Phase level crosses to the system side through the synchroniser
   assign conv_lvl = (phase_reg == PH_CONV);

   // Select high clears the frame; the clock may stand still outside frames
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt_reg <= '0; // R8 R9
         shift_reg <= '0;
         dout_reg <= 1'b0;
         phase_reg <= PH_IDLE;
         busy_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         dout_reg <= dout_next;
         phase_reg <= phase_next;
         busy_reg <= busy_next;
      end
   end

   // Toggles survive the frame; system reset seeds them equal to the seen copies
   always_ff @(negedge sclk or negedge nrst) begin
      if (!nrst) begin
         req_tgl_reg <= 1'b0;
         done_tgl_reg <= 1'b0;
      end else begin
         req_tgl_reg <= req_tgl_next;
         done_tgl_reg <= done_tgl_next;
      end
   end

   assign dout_o = dout_reg;
   // Enable follows select directly so release never waits for a clock
   assign dout_oe = ~cs_n; // R6

   // ---------------- System clock domain ----------------
   logic [sadc_pkg::SYNC_W-1:0] sync_in;
   logic [sadc_pkg::SYNC_W-1:0] sync_out;
   logic req_seen_reg;
   logic req_seen_next;
   logic done_seen_reg;
   logic done_seen_next;
   logic [sadc_pkg::CODE_W-1:0] held_next;
   sadc_pkg::sadc_result_t result_reg;
   sadc_pkg::sadc_result_t result_next;
   logic sample_req_reg;
   logic sample_req_next;
   logic abort_reg;
   logic abort_next;
   logic pending_reg;
   logic pending_next;
   sadc_pkg::sadc_status_t status_reg;
   sadc_pkg::sadc_status_t status_next;
   // Status is decoded from a small mode register
   typedef enum logic [1:0] {
      ST_DOWN,
      ST_ACQ,
      ST_CONV
   } sadc_mode_t;
   sadc_mode_t mode_reg;
   sadc_mode_t mode_next;
   logic req_s;
   logic done_s;
   logic cs_s;
   logic conv_s;

   // Busy is only a hint; the pending flag below is the real abort record
   assign sync_in = {req_tgl_reg, done_tgl_reg, cs_n, conv_lvl};

   sadc_sync2 #(
      .W(sadc_pkg::SYNC_W)
   ) u_sync (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .d(sync_in),
      .q(sync_out)
   );

   // Bit order follows the packing of sync_in
   assign req_s = sync_out[3];
   assign done_s = sync_out[2];
   assign cs_s = sync_out[1];
   assign conv_s = sync_out[0];

   always_comb begin
      req_seen_next = req_seen_reg;
      done_seen_next = done_seen_reg;
      held_next = held_reg;
      result_next = result_reg;
      result_next.valid = 1'b0;
      sample_req_next = 1'b0;
      if (ce) begin
         if (req_s != req_seen_reg) begin
            req_seen_next = req_s;
            // Code is frozen here, well before the hold edge reads it
            held_next = sample_code; // R5
            sample_req_next = 1'b1;
         end
         // Completion hands over the code that this conversion took
         if (done_s != done_seen_reg) begin
            done_seen_next = done_s;
            result_next.code = held_reg; // R15
            result_next.valid = 1'b1;
         end
      end
   end

   // Abort record: a sample was taken and no completion followed it
   always_comb begin
      pending_next = pending_reg;
      abort_next = 1'b0;
      if (ce) begin
         if (req_s != req_seen_reg) begin
            pending_next = 1'b1;
         end
         if (done_s != done_seen_reg) begin
            pending_next = 1'b0;
         end
         if (cs_s && pending_reg && (done_s == done_seen_reg)) begin
            abort_next = 1'b1; // R8
            pending_next = 1'b0;
         end
      end
   end

   // Status mirrors the synchronised select and phase, frozen while ce is low
   always_comb begin
      mode_next = mode_reg;
      if (ce) begin
         case (mode_reg)
            ST_DOWN: begin
               if (!cs_s) begin
                  mode_next = conv_s ? ST_CONV : ST_ACQ;
               end
            end
            ST_ACQ, ST_CONV: begin
               if (cs_s) begin
                  mode_next = ST_DOWN; // R7
               end else begin
                  mode_next = conv_s ? ST_CONV : ST_ACQ; // R2
               end
            end
            default: begin
               mode_next = ST_DOWN;
            end
         endcase
      end
      status_next = status_reg;
      if (ce) begin
         status_next.power_down = (mode_next == ST_DOWN); // R7
         status_next.acquisition_phase = (mode_next == ST_ACQ); // R2 R14
         status_next.conversion_phase = (mode_next == ST_CONV); // R2
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         req_seen_reg <= 1'b0;
         done_seen_reg <= 1'b0;
         held_reg <= sadc_pkg::CODE_RESET;
         result_reg <= '0;
         sample_req_reg <= 1'b0;
         abort_reg <= 1'b0;
         pending_reg <= 1'b0;
         status_reg <= '0;
         mode_reg <= ST_DOWN;
      end else begin
         req_seen_reg <= req_seen_next;
         done_seen_reg <= done_seen_next;
         held_reg <= held_next;
         result_reg <= result_next;
         sample_req_reg <= sample_req_next;
         abort_reg <= abort_next;
         pending_reg <= pending_next;
         status_reg <= status_next;
         mode_reg <= mode_next;
      end
   end

   assign sample_req = sample_req_reg;
   assign conv_abort = abort_reg;
   assign result = result_reg;
   assign status = status_reg;

endmodule

// ### core/sadc_sync2.sv
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/1ps
module sadc_sync2 #(
   parameter int W = 1
) (
   // System side
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Levels from another domain
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = meta_reg;
      q_next = q_reg;
      if (ce) begin
         meta_next = d;
         q_next = meta_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule

// ### tb/sadc_asserts.sv
// Port checker for the serial readout
`timescale 1ns/1ps
module sadc_chk (
   // System clock
   input wire logic clk,
   input wire logic nrst,
   // Core side
   input wire logic sample_req,
   input wire logic conv_abort,
   input wire sadc_pkg::sadc_result_t result,
   input wire sadc_pkg::sadc_status_t status,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic dout_o,
   input wire logic dout_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Five idle samples outlast the status synchroniser
   sequence idle_s;
      cs_n [*5];
   endsequence
   oe_follow_a: assert property (dout_oe == !cs_n) else $error("enable off select");
   idle_low_a: assert property (cs_n |-> !dout_o) else $error("data not cleared");
   pd_mode_a: assert property (idle_s |=> status.power_down) else $error("no power down");
   fall_only_a: assert property (!cs_n && $past(!cs_n) && $changed(dout_o) |-> $past(sclk) && !sclk)
      else $error("data moved off a fall");
   one_phase_a: assert property (!(status.acquisition_phase && status.conversion_phase))
      else $error("two phases");
   req_pulse_a: assert property (sample_req |=> !sample_req) else $error("long request");
   req_frame_a: assert property (sample_req |-> !$past(cs_n, 3)) else $error("request when idle");
   abort_cs_a: assert property (conv_abort |-> $past(cs_n, 3)) else $error("abort in frame");
   val_pulse_a: assert property (result.valid |=> !result.valid) else $error("long valid");
endmodule
bind sadc_serial_readout sadc_chk i_chk (.clk(clk), .nrst(nrst), .sample_req(sample_req),
   .conv_abort(conv_abort), .result(result), .status(status), .sclk(sclk), .cs_n(cs_n),
   .dout_o(dout_o), .dout_oe(dout_oe));

// ### tb/sadc_host.sv
// Host model that frames and clocks the serial link
`timescale 1ns/1ps
module sadc_host (
   // Link
   output logic sclk,
   output logic cs_n,
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic last;
   logic line;
   // No pull on the line; a released line shows the inverse bit
   assign line = dout_oe ? dout_o : ~last;
   always @(posedge sclk) last <= line;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      last = 1'b0;
      repeat (2) begin
         #80 sclk = 1'b0;
         #80 sclk = 1'b1;
      end
   end
   // Mode 0 select falls with clock high, 1 with clock low, 2 with clock falling 1 ns after select
   task run(input int mode, input int n, output logic [31:0] w);
      w = '0;
      if (mode == 1) begin
         sclk = 1'b0;
         #80;
      end
      cs_n = 1'b0;
      if (mode == 2) #1 sclk = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (i > 0 || mode == 0) #80 sclk = 1'b0;
         #80 sclk = 1'b1;
         w = {w[30:0], line};
      end
      #80 cs_n = 1'b1;
   endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the serial readout
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [1:0] mode;
      logic [11:0] code;
   } sadc_row_t;
   logic clk;
   logic nrst;
   logic ce;
   logic [sadc_pkg::CODE_W-1:0] sample_code;
   logic sample_req;
   logic conv_abort;
   sadc_pkg::sadc_result_t result;
   sadc_pkg::sadc_status_t status;
   logic sclk;
   logic cs_n;
   logic dout_o;
   logic dout_oe;
   logic [31:0] w;
   int bad_count;
   int tests_run;
   int cyc;
   int nval;
   int nab;
   sadc_row_t rows [4] = '{'{2'h0, 12'h7ff}, '{2'h1, 12'h000}, '{2'h2, 12'hfff}, '{2'h0, 12'h800}};
   sadc_serial_readout i_dut (.clk(clk), .nrst(nrst), .ce(ce), .sample_code(sample_code),
      .sample_req(sample_req), .conv_abort(conv_abort), .result(result), .status(status),
      .sclk(sclk), .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe));
   sadc_host i_host (.sclk(sclk), .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (result.valid === 1'b1) nval <= nval + 1;
      if (conv_abort === 1'b1) nab <= nab + 1;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      sample_code = 12'h000;
      repeat (16) @(posedge clk);
      #1 nrst = 1'b1;
      @(posedge clk) #1;
      check(result, '0);
      check(sample_req, 1'b0);
      repeat (100) @(posedge clk);
      #1 check(status, 3'h4);
      foreach (rows[k]) begin
         sample_code = rows[k].code;
         i_host.run(rows[k].mode, 16, w);
         repeat (10) @(posedge clk);
         #1 check(w, {20'h0, rows[k].code});
         check(result.code, rows[k].code);
         check(nval, k + 1);
         check(dout_oe, 1'b0);
      end
      // Second sample must be taken mid-frame, not reused
      sample_code = 12'h5a3;
      fork
         i_host.run(0, 32, w);
         begin
            repeat (200) @(posedge clk);
            #1 sample_code = 12'h3c6;
         end
      join
      repeat (10) @(posedge clk);
      #1 check(w, 32'h05a303c6);
      check(nval, 6);
      check(nab, 0);
      i_host.run(1, 8, w);
      repeat (10) @(posedge clk);
      #1 check(w, 32'h3);
      check(nab, 1);
      check(nval, 6);
      check(result.code, 12'h3c6);
      print_verdict();
   end
endmodule
